// file: hdl/gateway_consts.vh
`ifndef GATEWAY_CONSTS_VH
`define GATEWAY_CONSTS_VH

// ----------------------------------------------------------------
// input data area layout (toward the io controller)
// ----------------------------------------------------------------
`define IN_AREA_BYTES     16'h0200
`define IN_HDR_BYTES      16'h0008
`define IN_DATA_BYTES     16'h01f8
`define OFS_STATE         9'h000
`define OFS_ERR           9'h001
`define OFS_LEN_HI        9'h002
`define OFS_LEN_LO        9'h003
`define OFS_RXC_HI        9'h004
`define OFS_RXC_LO        9'h005
`define OFS_TXC_HI        9'h006
`define OFS_TXC_LO        9'h007

// ----------------------------------------------------------------
// transfer state codes and error flag bits
// ----------------------------------------------------------------
`define ST_IDLE           8'h00
`define ST_TX             8'h01
`define ST_RX             8'h02
`define ERR_OUT_FIFO_OVF  0
`define ERR_IN_FIFO_OVF   1
`define ERR_OUT_LOSS      2
`define ERR_IN_LOSS       3
`define ERR_IN_DATA_OVF   4

// ----------------------------------------------------------------
// output data area layout (from the io controller)
// ----------------------------------------------------------------
`define OUT_AREA_BYTES    16'h0180
`define OUT_DATA_BYTES    16'h0178
`define OFS_CMD           9'h000
`define OFS_CTRL          9'h001
`define OFS_OLEN_HI       9'h002
`define OFS_OLEN_LO       9'h003
`define OFS_FIX_HI        9'h004
`define OFS_FIX_LO        9'h005
`define OFS_TMO           9'h007
`define OFS_ODATA         9'h008
`define CTRL_CLR_DIAG     0
`define CTRL_CLR_RXC      1
`define CTRL_CLR_TXC      2

// ----------------------------------------------------------------
// packet delimiting modes and timing
// ----------------------------------------------------------------
`define MODE_INTERVAL     2'h0
`define MODE_FIXED        2'h1
`define MODE_ENDCHAR      2'h2
`define CLK_PERIOD_NS     10
`define TMO_UNIT_US       1000
`define TAIL_BYTES        3
`define SER_IN_DEPTH      512

`endif

// file: hdl/fieldbus_serial_gateway_status.v
`timescale 1ns/1ps
`default_nettype none
`include "gateway_consts.vh"

module fieldbus_serial_gateway_status #(
    parameter integer BYTE_CYCLES = 8681,
    parameter integer UNIT_CYCLES = `TMO_UNIT_US * 1000 / `CLK_PERIOD_NS
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        fb_wr_en,
    input  wire [8:0]  fb_wr_addr,
    input  wire [7:0]  fb_wr_data,
    input  wire        fb_cycle_done,
    input  wire [8:0]  fb_rd_addr,
    output reg  [7:0]  fb_rd_data_q,
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    output reg         tx_valid_q,
    output reg  [7:0]  tx_data_q,
    input  wire        tx_ready,
    input  wire [1:0]  pkt_mode,
    input  wire [7:0]  end_char
);

    // ----------------------------------------------------------------
    // the four buffers
    // ----------------------------------------------------------------
    reg [7:0] fb_in   [0:`OUT_AREA_BYTES-1];
    reg [7:0] fb_out  [0:`IN_DATA_BYTES-1];
    reg [7:0] ser_in  [0:`SER_IN_DEPTH-1];
    reg [7:0] ser_out [0:`OUT_DATA_BYTES-1];

    localparam [1:0] TX_IDLE = 2'd0;
    localparam [1:0] TX_COPY = 2'd1;
    localparam [1:0] TX_SEND = 2'd2;

    localparam [31:0] BYTE_T = BYTE_CYCLES;
    localparam [31:0] UNIT_T = UNIT_CYCLES;
    localparam [31:0] TAIL_T = BYTE_CYCLES * `TAIL_BYTES;

    reg [1:0]  tx_st_q;
    reg [8:0]  tx_i_q;
    reg [8:0]  tx_len_q;
    reg [7:0]  last_cmd_q;
    reg [4:0]  err_q;
    reg [15:0] pkt_len_q;
    reg [15:0] rxc_q;
    reg [15:0] txc_q;
    reg [9:0]  rx_cnt_q;
    reg [31:0] gap_q;
    reg        match_q;
    reg        rc_busy_q;
    reg [8:0]  rc_i_q;
    reg [8:0]  rc_len_q;

    wire [7:0]  cmd      = fb_in[`OFS_CMD];
    wire [7:0]  ctrl     = fb_in[`OFS_CTRL];
    wire [15:0] out_len  = {fb_in[`OFS_OLEN_HI], fb_in[`OFS_OLEN_LO]};
    wire [15:0] fix_len  = {fb_in[`OFS_FIX_HI], fb_in[`OFS_FIX_LO]};
    wire [7:0]  tmo_val  = fb_in[`OFS_TMO];
    wire [31:0] tmo_cyc  = (tmo_val == 8'h00) ? BYTE_T : UNIT_T * {24'h00_0000, tmo_val};

    // ----------------------------------------------------------------
    // packet end detection
    // ----------------------------------------------------------------
    reg pkt_end;
    always @*
    begin
        pkt_end = 1'b0;
        if (rx_cnt_q != 10'h000)
        begin
            case (pkt_mode)
                `MODE_INTERVAL: pkt_end = (gap_q > tmo_cyc);
                `MODE_FIXED:    pkt_end = ((fix_len != 16'h0000) && ({6'h00, rx_cnt_q} == fix_len))
                                          || (gap_q > TAIL_T);
                `MODE_ENDCHAR:  pkt_end = match_q || (gap_q > TAIL_T);
                default:        pkt_end = (gap_q > tmo_cyc);
            endcase
        end
    end

    // new command is recognised only by a change of the command byte
    wire new_cmd  = fb_cycle_done && (cmd != last_cmd_q);
    wire cmd_skip = new_cmd && (cmd != last_cmd_q + 8'h01);
    wire len_big  = (out_len > `OUT_DATA_BYTES);
    wire rx_full  = (rx_cnt_q == `SER_IN_DEPTH);
    wire pkt_big  = ({6'h00, rx_cnt_q} > `IN_DATA_BYTES);
    wire tx_take  = (tx_st_q == TX_SEND) && (!tx_valid_q || tx_ready);
    wire tx_done  = tx_valid_q && tx_ready;
    // lengths are capped at full width, then narrowed on purpose
    wire [15:0] out_cap = len_big ? `OUT_DATA_BYTES : out_len;
    wire [15:0] rc_cap  = pkt_big ? `IN_DATA_BYTES : {6'h00, rx_cnt_q};

    // ----------------------------------------------------------------
    // fieldbus side: controller writes, status and data readback
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (fb_wr_en && (fb_wr_addr < `OUT_AREA_BYTES))
            fb_in[fb_wr_addr] <= fb_wr_data;
    end

    // read data is one cycle late; status bytes come from live registers
    always @(posedge clk)
    begin
        if (rst)
            fb_rd_data_q <= 8'h00;
        else
        begin
            case (fb_rd_addr)
                `OFS_STATE:  fb_rd_data_q <= (tx_st_q != TX_IDLE) ? `ST_TX :
                                             ((rx_cnt_q != 10'h000) || rc_busy_q) ? `ST_RX : `ST_IDLE;
                `OFS_ERR:    fb_rd_data_q <= {3'h0, err_q};
                `OFS_LEN_HI: fb_rd_data_q <= pkt_len_q[15:8];
                `OFS_LEN_LO: fb_rd_data_q <= pkt_len_q[7:0];
                `OFS_RXC_HI: fb_rd_data_q <= rxc_q[15:8];
                `OFS_RXC_LO: fb_rd_data_q <= rxc_q[7:0];
                `OFS_TXC_HI: fb_rd_data_q <= txc_q[15:8];
                `OFS_TXC_LO: fb_rd_data_q <= txc_q[7:0];
                default:     fb_rd_data_q <= fb_out[fb_rd_addr - `OFS_ODATA];
            endcase
        end
    end

    // ----------------------------------------------------------------
    // transmit path: fieldbus input buffer to serial output buffer
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (tx_st_q == TX_COPY)
            ser_out[tx_i_q] <= fb_in[tx_i_q + `OFS_ODATA];
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            tx_st_q    <= TX_IDLE;
            tx_i_q     <= 9'h000;
            tx_len_q   <= 9'h000;
            last_cmd_q <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
        end
        else
        begin
            if (fb_cycle_done)
                last_cmd_q <= cmd;
            if (tx_done)
                tx_valid_q <= 1'b0;
            case (tx_st_q)
                TX_IDLE:
                begin
                    // a zero length command sends nothing
                    if (new_cmd && (out_len != 16'h0000))
                    begin
                        tx_st_q  <= TX_COPY;
                        tx_i_q   <= 9'h000;
                        tx_len_q <= out_cap[8:0];
                    end
                end
                TX_COPY:
                begin
                    if (tx_i_q == tx_len_q - 9'h001)
                    begin
                        tx_st_q <= TX_SEND;
                        tx_i_q  <= 9'h000;
                    end
                    else
                        tx_i_q <= tx_i_q + 9'h001;
                end
                TX_SEND:
                begin
                    if (tx_take)
                    begin
                        if (tx_i_q == tx_len_q)
                            tx_st_q <= TX_IDLE;
                        else
                        begin
                            tx_valid_q <= 1'b1;
                            tx_data_q  <= ser_out[tx_i_q];
                            tx_i_q     <= tx_i_q + 9'h001;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive path: serial input buffer to fieldbus output buffer
    // ----------------------------------------------------------------
    // byte 0 is copied in the end cycle itself, so the copy never falls
    // behind a new packet refilling the serial buffer from index 0
    wire [9:0] wr_idx = pkt_end ? 10'h000 : rx_cnt_q;

    always @(posedge clk)
    begin
        if (rx_valid && !(rx_full && !pkt_end))
            ser_in[wr_idx[8:0]] <= rx_data;
        if (pkt_end && !rc_busy_q)
            fb_out[9'h000] <= ser_in[9'h000];
        else if (rc_busy_q)
            fb_out[rc_i_q] <= ser_in[rc_i_q];
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            rx_cnt_q  <= 10'h000;
            gap_q     <= 32'h0000_0000;
            match_q   <= 1'b0;
            rc_busy_q <= 1'b0;
            rc_i_q    <= 9'h000;
            rc_len_q  <= 9'h000;
            pkt_len_q <= 16'h0000;
        end
        else
        begin
            if (rx_valid)
            begin
                gap_q   <= 32'h0000_0000;
                match_q <= (rx_data == end_char);
                if (pkt_end)
                    rx_cnt_q <= 10'h001;
                else if (!rx_full)
                    rx_cnt_q <= rx_cnt_q + 10'h001;
            end
            else
            begin
                if (pkt_end)
                    rx_cnt_q <= 10'h000;
                if (pkt_end)
                    match_q <= 1'b0;
                if ((rx_cnt_q != 10'h000) && (gap_q != 32'hffff_ffff))
                    gap_q <= gap_q + 32'h0000_0001;
            end
            if (rc_busy_q)
            begin
                if (rc_i_q == rc_len_q - 9'h001)
                    rc_busy_q <= 1'b0;
                rc_i_q <= rc_i_q + 9'h001;
            end
            // a packet ending while the previous copy still runs is dropped
            if (pkt_end && !rc_busy_q)
            begin
                rc_busy_q <= (rx_cnt_q != 10'h001);
                rc_i_q    <= 9'h001;
                rc_len_q  <= rc_cap[8:0];
                pkt_len_q <= {6'h00, rx_cnt_q};
            end
        end
    end

    // ----------------------------------------------------------------
    // error flags and traffic counters
    // ----------------------------------------------------------------
    wire [4:0] err_set = {pkt_end && pkt_big,
                          pkt_end && rc_busy_q,
                          cmd_skip,
                          rx_valid && rx_full && !pkt_end,
                          new_cmd && ((tx_st_q != TX_IDLE) || len_big)};

    always @(posedge clk)
    begin
        if (rst)
        begin
            err_q <= 5'h00;
            rxc_q <= 16'h0000;
            txc_q <= 16'h0000;
        end
        else
        begin
            // a new error in the clearing cycle still shows
            err_q <= (ctrl[`CTRL_CLR_DIAG] ? 5'h00 : err_q) | err_set;
            if (ctrl[`CTRL_CLR_RXC])
                rxc_q <= 16'h0000;
            else if (rx_valid)
                rxc_q <= rxc_q + 16'h0001;
            if (ctrl[`CTRL_CLR_TXC])
                txc_q <= 16'h0000;
            else if (tx_done)
                txc_q <= txc_q + 16'h0001;
        end
    end

endmodule

`default_nettype wire

// file: tb/gateway_props.sv
`timescale 1ns/1ps
`default_nettype none
module gateway_props #(
    parameter integer BYTE_CYCLES = 8681,
    parameter integer UNIT_CYCLES = 100000
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       fb_wr_en,
    input wire logic [8:0] fb_wr_addr,
    input wire logic [7:0] fb_wr_data,
    input wire logic       fb_cycle_done,
    input wire logic [8:0] fb_rd_addr,
    input wire logic [7:0] fb_rd_data_q,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       tx_valid_q,
    input wire logic [7:0] tx_data_q,
    input wire logic       tx_ready,
    input wire logic [1:0] pkt_mode,
    input wire logic [7:0] end_char
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    logic seen_q;
    always @(posedge clk)
    begin
        seen_q <= rst ? 1'b0 : (seen_q | fb_cycle_done);
    end
    AST_TX_HOLD: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
        else $error("serial byte dropped or changed before accept");
    AST_TX_CAUSE: assert property ($rose(tx_valid_q) |-> seen_q)
        else $error("serial send without a prior exchange");
    AST_STATE_CODE: assert property (fb_rd_addr == 9'h000 |=> fb_rd_data_q <= 8'h02)
        else $error("transfer state code out of range");
    AST_TX_STATE: assert property (tx_valid_q && fb_rd_addr == 9'h000 |=> fb_rd_data_q == 8'h01)
        else $error("transfer state not transmitting during send");
    AST_ERR_UPPER: assert property (fb_rd_addr == 9'h001 |=> fb_rd_data_q[7:5] == 3'h0)
        else $error("unused error flag bits set");
    AST_POST_RST: assert property ($past(rst) && fb_rd_addr < 9'h008 |=> fb_rd_data_q == 8'h00)
        else $error("status not zero right after reset");
    AST_RST_RD: assert property ($past(rst) |-> fb_rd_data_q == 8'h00 && !tx_valid_q)
        else $error("read data or send strobe not cleared by reset");
    AST_RST_TXD: assert property ($past(rst) |-> tx_data_q == 8'h00)
        else $error("send data not cleared by reset");
    COV_ACCEPT: cover property (tx_valid_q && tx_ready);
    COV_RX: cover property (rx_valid);
    COV_EXCH: cover property (fb_cycle_done);
endmodule
bind fieldbus_serial_gateway_status gateway_props #(.BYTE_CYCLES(BYTE_CYCLES), .UNIT_CYCLES(UNIT_CYCLES)) props (
    .clk(clk), .rst(rst), .fb_wr_en(fb_wr_en), .fb_wr_addr(fb_wr_addr), .fb_wr_data(fb_wr_data),
    .fb_cycle_done(fb_cycle_done), .fb_rd_addr(fb_rd_addr), .fb_rd_data_q(fb_rd_data_q),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .tx_ready(tx_ready), .pkt_mode(pkt_mode), .end_char(end_char)
);
`default_nettype wire

// file: tb/plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module plc_model (
    input  wire logic       clk,
    output var  logic       fb_wr_en,
    output var  logic [8:0] fb_wr_addr,
    output var  logic [7:0] fb_wr_data,
    output var  logic       fb_cycle_done,
    output var  logic [8:0] fb_rd_addr,
    input  wire logic [7:0] fb_rd_data_q
);
    logic [7:0] out_img [0:383];
    initial
    begin
        fb_wr_en = 1'b0;
        fb_wr_addr = 9'h000;
        fb_wr_data = 8'h00;
        fb_cycle_done = 1'b0;
        fb_rd_addr = 9'h000;
        foreach (out_img[i]) out_img[i] = 8'h00;
    end
    // ------------------------------------------------
    // whole image goes over every cycle, changed or not
    // ------------------------------------------------
    task automatic exchange();
        for (int i = 0; i < 384; i++)
        begin
            @(posedge clk);
            #1;
            fb_wr_en = 1'b1;
            fb_wr_addr = i[8:0];
            fb_wr_data = out_img[i];
        end
        @(posedge clk);
        #1;
        fb_wr_en = 1'b0;
        fb_wr_data = ~fb_wr_data;
        fb_cycle_done = 1'b1;
        @(posedge clk);
        #1;
        fb_cycle_done = 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        fb_rd_addr = a;
        @(posedge clk);
        #1;
        d = fb_rd_data_q;
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gateway_consts.vh"
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rx_valid = 1'b0;
    logic [7:0]  rx_data = 8'h00;
    logic        tx_ready = 1'b0;
    logic [1:0]  pkt_mode = 2'h0;
    logic [7:0]  end_char = 8'h0d;
    wire         fb_wr_en, fb_cycle_done, tx_valid_q;
    wire  [8:0]  fb_wr_addr, fb_rd_addr;
    wire  [7:0]  fb_wr_data, fb_rd_data_q, tx_data_q;
    logic [7:0]  txq[$];
    logic [15:0] v;
    int          fail_count = 0;
    int          n_checks = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (tx_valid_q && tx_ready) txq.push_back(tx_data_q);
    fieldbus_serial_gateway_status #(.BYTE_CYCLES(4), .UNIT_CYCLES(10)) dut (
        .clk(clk), .rst(rst), .fb_wr_en(fb_wr_en), .fb_wr_addr(fb_wr_addr), .fb_wr_data(fb_wr_data),
        .fb_cycle_done(fb_cycle_done), .fb_rd_addr(fb_rd_addr), .fb_rd_data_q(fb_rd_data_q),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
        .tx_ready(tx_ready), .pkt_mode(pkt_mode), .end_char(end_char));
    plc_model plc (.clk(clk), .fb_wr_en(fb_wr_en), .fb_wr_addr(fb_wr_addr), .fb_wr_data(fb_wr_data),
        .fb_cycle_done(fb_cycle_done), .fb_rd_addr(fb_rd_addr), .fb_rd_data_q(fb_rd_data_q));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // 16-bit values sit high byte first
    task automatic rd16(input logic [8:0] a, output logic [15:0] r);
        logic [7:0] h;
        logic [7:0] l;
        plc.rd(a, h);
        plc.rd(a + 9'h001, l);
        r = {h, l};
    endtask
    task automatic exch(input logic [7:0] cmd, input logic [7:0] ctrl);
        plc.out_img[0] = cmd;
        plc.out_img[1] = ctrl;
        plc.exchange();
        repeat (20) @(posedge clk);
    endtask
    task automatic rx_pkt(input logic [1:0] m, input int n, input int gap);
        logic [7:0] b;
        pkt_mode = m;
        for (int i = 0; i < n; i++)
        begin
            b = (m == `MODE_ENDCHAR && i == n - 1) ? end_char : 8'hb0 + i[7:0];
            @(posedge clk);
            #1;
            rx_valid = 1'b1;
            rx_data = b;
            @(posedge clk);
            #1;
            rx_valid = 1'b0;
            rx_data = ~b;
            repeat (gap) @(posedge clk);
        end
        repeat (40) @(posedge clk);
        rd16(`OFS_LEN_HI, v);
        chk("rx_len", 16'(n), v);
        rd16(9'h008, v);
        chk("rx_head", {8'hb0, n == 2 ? end_char : 8'hb1}, v);
    endtask
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        rd16(`OFS_STATE, v);
        chk("state_err", 16'h0000, v);
        plc.out_img[3] = 8'h03;
        plc.out_img[8] = 8'h11;
        plc.out_img[9] = 8'h22;
        plc.out_img[10] = 8'h33;
        exch(8'h01, 8'h00);
        rd16(`OFS_STATE, v);
        chk("state_err", {`ST_TX, 8'h00}, v);
        tx_ready = 1'b1;
        for (int i = 0; i < 50 && txq.size() < 3; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        chk("tx_n", 16'h0003, 16'(txq.size()));
        for (int i = 0; i < 3; i++) chk("tx_byte", 16'(8'h11 * (i + 1)), {8'h00, txq[i]});
        rd16(`OFS_TXC_HI, v);
        chk("tx_count", 16'h0003, v);
        rd16(`OFS_STATE, v);
        chk("state_err", {`ST_IDLE, 8'h00}, v);
        plc.out_img[3] = 8'h01;
        exch(8'h03, 8'h00);
        rd16(`OFS_STATE, v);
        chk("state_err", 16'h0004, v);
        exch(8'h03, 8'h01);
        rd16(`OFS_STATE, v);
        chk("state_err", 16'h0000, v);
        plc.out_img[5] = 8'h04;
        exch(8'h03, 8'h00);
        rx_pkt(`MODE_FIXED, 4, 0);
        rx_pkt(`MODE_ENDCHAR, 2, 3);
        rx_pkt(`MODE_INTERVAL, 3, 1);
        rd16(`OFS_RXC_HI, v);
        chk("rx_count", 16'h0009, v);
        pkt_mode = `MODE_FIXED;
        rx_valid = 1'b1;
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rd16(`OFS_STATE, v);
        chk("state_err", {`ST_RX, 8'h00}, v);
        plc.out_img[2] = 8'h02;
        exch(8'h04, 8'h06);
        rd16(`OFS_STATE, v);
        chk("state_err", {`ST_TX, 8'h01}, v);
        rd16(`OFS_RXC_HI, v);
        chk("rx_count", 16'h0000, v);
        rd16(`OFS_TXC_HI, v);
        chk("tx_count", 16'h0000, v);
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
